// ---- macr_cfg_if.sv ----
`timescale 1ns/1ps
// control bits of one tightly coupled memory port, from bank to router
interface macr_cfg_if;
    logic enable;
    logic retry_enable;
    logic partial_write_merge_enable;
    modport bank  (output enable, output retry_enable, output partial_write_merge_enable);
    modport route (input  enable, input  retry_enable, input  partial_write_merge_enable);
endinterface : macr_cfg_if

// ---- macr_far_model.sv ----
`timescale 1ns/1ps
module macr_far_model (
    // clock
    input  wire logic mclk,
    // retry outputs of the two memories
    output logic      imem_retry,
    output logic      dmem_retry
);
    logic [7:0] pat;

    initial begin
        pat        = 8'h5a;
        imem_retry = 1'b0;
        dmem_retry = 1'b1;
    end

    // retry is resampled from a shift pattern at every falling edge, so consecutive samples can repeat
    always @(negedge mclk) begin
        pat        <= {pat[6:0], pat[7] ^ pat[5]};
        imem_retry <= pat[0];
        dmem_retry <= pat[3];
    end
endmodule : macr_far_model

// ---- macr_pkg.sv ----
package macr_pkg;
    // register addresses on the private peripheral bus
    localparam logic [31:0] MACR_ADDR_ITCM  = 32'he000_ef90;
    localparam logic [31:0] MACR_ADDR_DTCM  = 32'he000_ef94;
    localparam logic [31:0] MACR_ADDR_PPORT = 32'he000_ef98;
    localparam logic [31:0] MACR_ADDR_CACHE = 32'he000_ef9c;
    // tightly coupled memory control fields
    localparam int TM_EN_BIT    = 0;
    localparam int TM_MERGE_BIT = 1;
    localparam int TM_RETRY_BIT = 2;
    localparam int TM_SIZE_LSB  = 3;
    localparam int TM_SIZE_MSB  = 6;
    // peripheral port fields
    localparam int PP_EN_BIT    = 0;
    localparam int PP_SIZE_LSB  = 1;
    localparam int PP_SIZE_MSB  = 3;
    // auxiliary cache fields
    localparam int AC_SHARED_BIT = 0;
    localparam int AC_ECC_BIT    = 1;
    localparam int AC_FWT_BIT    = 2;
    // size encodings
    localparam logic [3:0] TM_SIZE_NONE = 4'h0;
    localparam logic [3:0] TM_SIZE_4K   = 4'h3;
    localparam logic [3:0] TM_SIZE_16M  = 4'hf;
    localparam logic [2:0] PP_SIZE_64M  = 3'h1;
    localparam logic [2:0] PP_SIZE_512M = 3'h4;
    // reset values of software-owned bits
    localparam logic       RST_CTRL_BIT = 1'b0;
    localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

    // cache policy of a cacheable access after overrides
    typedef enum logic [1:0] {
        MACR_POL_WB = 2'b00,
        MACR_POL_WT = 2'b01,
        MACR_POL_NC = 2'b10
    } macr_policy_t;
endpackage : macr_pkg

// ---- macr_regs.sv ----
// Operation
// - two tightly coupled memory control registers share one layout.
// - memory enable clear sends that memory's accesses to the AXI master.
// - read-only size field reports memory size; 0 none, 3 is 4KB doubling.
// - retry enable set makes the core honour the memory retry output.
// - merge enable set turns narrow writes into read-modify-write.
// - memory enables take their reset state from strap inputs.
// - retry and merge enables take their reset state from strap inputs.
// - reserved bits read zero and ignore writes.
// - peripheral port size is a read-only three-bit field.
// - peripheral port enable clear sends its accesses to AXI; strapped reset.
// - force write-through makes write-back regions write-through.
// - cache ECC bit is inverted: zero enables checking.
// - ECC bit ignores writes without caches or ECC; resets per configuration.
// - shared-coherency clear makes shared cacheable locations non-cacheable.
// - shared-coherency set: data write-through, instruction non-cacheable.
// - write-through and shared bits read zero without a data cache.
// - after reset registers read zero apart from straps, sizes and the ECC bit, which reads one without cache ECC.
// - only privileged accesses may modify the registers.
`timescale 1ns/1ps
module macr_regs
    import macr_pkg::*;
#(
    parameter logic [3:0] ITCM_SIZE     = 4'h3,
    parameter logic [3:0] DTCM_SIZE     = 4'h3,
    parameter logic [2:0] PPORT_SIZE    = 3'h1,
    parameter bit         HAS_DCACHE    = 1'b1,
    parameter bit         HAS_ICACHE    = 1'b1,
    parameter bit         HAS_CACHE_ECC = 1'b1
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // register port
    input  wire logic         reg_sel,
    input  wire logic         reg_write,
    input  wire logic         reg_priv,
    input  wire logic [31:0]  reg_addr,
    input  wire logic [31:0]  reg_wdata,
    output logic      [31:0]  reg_rdata,
    output logic              reg_hit,
    // reset straps, from pins
    input  wire logic         strap_itcm_en,
    input  wire logic         strap_dtcm_en,
    input  wire logic         strap_tm_retry,
    input  wire logic         strap_tm_merge,
    input  wire logic         strap_pport_en,
    // instruction memory access
    input  wire logic         iacc_valid,
    input  wire logic         iacc_write,
    input  wire logic         iacc_partial,
    input  wire logic         imem_retry,
    output logic              iacc_to_mem,
    output logic              iacc_to_axi,
    output logic              iacc_merge,
    output logic              iacc_retry,
    // data memory access
    input  wire logic         dacc_valid,
    input  wire logic         dacc_write,
    input  wire logic         dacc_partial,
    input  wire logic         dmem_retry,
    output logic              dacc_to_mem,
    output logic              dacc_to_axi,
    output logic              dacc_merge,
    output logic              dacc_retry,
    // peripheral region access
    input  wire logic         pacc_valid,
    output logic              pacc_to_port,
    output logic              pacc_to_axi,
    // cache policy lookup
    input  wire logic         cacc_cacheable,
    input  wire logic         cacc_shared,
    input  wire logic         cacc_wback,
    output macr_pkg::macr_policy_t dcache_policy,
    output macr_pkg::macr_policy_t icache_policy,
    output logic              cache_ecc_on
);
    import macr_pkg::*;

    // strap synchronisers; two stages, the first read only by the second
    logic [4:0] strap_s1;
    logic [4:0] strap_s2;
    logic       rst_seen;
    logic       itcm_en, itcm_retry, itcm_merge;
    logic       dtcm_en, dtcm_retry, dtcm_merge;
    logic       pport_en;
    logic       fwt, ecc_dis, shared_wt;
    logic       wr_ok;
    logic       ecc_writable;

    always_ff @(posedge mclk) begin
        strap_s1 <= {strap_pport_en, strap_tm_merge, strap_tm_retry,
                     strap_dtcm_en, strap_itcm_en};
        strap_s2 <= strap_s1;
    end

    // straps are loaded on the first clock after reset release, once
    // synchronised; control bits before that hold constants
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rst_seen <= 1'b0;
        end else begin
            rst_seen <= 1'b1;
        end
    end

    assign wr_ok        = reg_sel & reg_write & reg_priv;
    assign ecc_writable = HAS_CACHE_ECC & (HAS_DCACHE | HAS_ICACHE);

    // instruction memory control
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            itcm_en    <= RST_CTRL_BIT;
            itcm_retry <= RST_CTRL_BIT;
            itcm_merge <= RST_CTRL_BIT;
        end else if (!rst_seen) begin
            itcm_en    <= strap_s2[0];
            itcm_retry <= strap_s2[2];
            itcm_merge <= strap_s2[3];
        end else if (wr_ok && reg_addr == MACR_ADDR_ITCM) begin
            itcm_en    <= reg_wdata[TM_EN_BIT];
            itcm_retry <= reg_wdata[TM_RETRY_BIT];
            itcm_merge <= reg_wdata[TM_MERGE_BIT];
        end
    end

    // data memory control, same layout
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dtcm_en    <= RST_CTRL_BIT;
            dtcm_retry <= RST_CTRL_BIT;
            dtcm_merge <= RST_CTRL_BIT;
        end else if (!rst_seen) begin
            dtcm_en    <= strap_s2[1];
            dtcm_retry <= strap_s2[2];
            dtcm_merge <= strap_s2[3];
        end else if (wr_ok && reg_addr == MACR_ADDR_DTCM) begin
            dtcm_en    <= reg_wdata[TM_EN_BIT];
            dtcm_retry <= reg_wdata[TM_RETRY_BIT];
            dtcm_merge <= reg_wdata[TM_MERGE_BIT];
        end
    end

    // peripheral port control
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pport_en <= RST_CTRL_BIT;
        end else if (!rst_seen) begin
            pport_en <= strap_s2[4];
        end else if (wr_ok && reg_addr == MACR_ADDR_PPORT) begin
            pport_en <= reg_wdata[PP_EN_BIT];
        end
    end

    // auxiliary cache control
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fwt       <= RST_CTRL_BIT;
            shared_wt <= RST_CTRL_BIT;
            ecc_dis   <= ~HAS_CACHE_ECC;
        end else if (wr_ok && reg_addr == MACR_ADDR_CACHE) begin
            fwt       <= HAS_DCACHE & reg_wdata[AC_FWT_BIT];
            shared_wt <= HAS_DCACHE & reg_wdata[AC_SHARED_BIT];
            if (ecc_writable) begin
                ecc_dis <= reg_wdata[AC_ECC_BIT];
            end
        end
    end

    // read path; reserved bits read zero
    always_comb begin
        reg_rdata = ZERO_WORD;
        reg_hit   = 1'b1;
        case (reg_addr)
            MACR_ADDR_ITCM: begin
                reg_rdata[TM_SIZE_MSB:TM_SIZE_LSB] = ITCM_SIZE;
                reg_rdata[TM_RETRY_BIT] = itcm_retry;
                reg_rdata[TM_MERGE_BIT] = itcm_merge;
                reg_rdata[TM_EN_BIT]    = itcm_en;
            end
            MACR_ADDR_DTCM: begin
                reg_rdata[TM_SIZE_MSB:TM_SIZE_LSB] = DTCM_SIZE;
                reg_rdata[TM_RETRY_BIT] = dtcm_retry;
                reg_rdata[TM_MERGE_BIT] = dtcm_merge;
                reg_rdata[TM_EN_BIT]    = dtcm_en;
            end
            MACR_ADDR_PPORT: begin
                reg_rdata[PP_SIZE_MSB:PP_SIZE_LSB] = PPORT_SIZE;
                reg_rdata[PP_EN_BIT] = pport_en;
            end
            MACR_ADDR_CACHE: begin
                reg_rdata[AC_FWT_BIT]    = fwt;
                reg_rdata[AC_ECC_BIT]    = ecc_dis;
                reg_rdata[AC_SHARED_BIT] = shared_wt;
            end
            default: begin
                reg_hit = 1'b0;
            end
        endcase
        if (!reg_sel) begin
            reg_hit = 1'b0;
        end
    end

    // memory routing, one instance per port; settings act the cycle after
    // the write edge so every later access sees them
    macr_cfg_if icfg ();
    macr_cfg_if dcfg ();
    assign icfg.enable                     = itcm_en;
    assign icfg.retry_enable               = itcm_retry;
    assign icfg.partial_write_merge_enable = itcm_merge;
    assign dcfg.enable                     = dtcm_en;
    assign dcfg.retry_enable               = dtcm_retry;
    assign dcfg.partial_write_merge_enable = dtcm_merge;

    macr_tm_route u_iroute (
        .cfg          (icfg),
        .acc_valid    (iacc_valid),
        .acc_write    (iacc_write),
        .acc_partial  (iacc_partial),
        .mem_retry    (imem_retry),
        .to_mem       (iacc_to_mem),
        .to_axi       (iacc_to_axi),
        .use_merge    (iacc_merge),
        .honour_retry (iacc_retry)
    );

    macr_tm_route u_droute (
        .cfg          (dcfg),
        .acc_valid    (dacc_valid),
        .acc_write    (dacc_write),
        .acc_partial  (dacc_partial),
        .mem_retry    (dmem_retry),
        .to_mem       (dacc_to_mem),
        .to_axi       (dacc_to_axi),
        .use_merge    (dacc_merge),
        .honour_retry (dacc_retry)
    );

    assign pacc_to_port = pacc_valid & pport_en;
    assign pacc_to_axi  = pacc_valid & ~pport_en;
    assign cache_ecc_on = ~ecc_dis;

    // shared locations override write-through forcing
    always_comb begin
        dcache_policy = MACR_POL_NC;
        icache_policy = MACR_POL_NC;
        if (cacc_cacheable) begin
            if (cacc_shared) begin
                dcache_policy = shared_wt ? MACR_POL_WT : MACR_POL_NC;
                icache_policy = MACR_POL_NC;
            end else begin
                dcache_policy = (cacc_wback && !fwt) ? MACR_POL_WB : MACR_POL_WT;
                icache_policy = MACR_POL_WB;
            end
        end
    end

    // assertions
    a_unpriv_no_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (rst_seen && reg_sel && reg_write && !reg_priv) |=> $stable(itcm_en) && $stable(pport_en))
        else $error("unprivileged write changed a register");
    a_itcm_route: assert property (@(posedge mclk) disable iff (!rst_n)
        iacc_valid |-> (iacc_to_axi == !itcm_en) && (iacc_to_mem == itcm_en))
        else $error("instruction memory routing wrong");
    a_dtcm_route: assert property (@(posedge mclk) disable iff (!rst_n)
        (dacc_valid && !dtcm_en) |-> dacc_to_axi && !dacc_to_mem)
        else $error("disabled data memory not routed to axi");
    a_retry_gate: assert property (@(posedge mclk) disable iff (!rst_n)
        iacc_retry |-> itcm_retry && imem_retry)
        else $error("retry honoured while disabled");
    a_merge_gate: assert property (@(posedge mclk) disable iff (!rst_n)
        (dacc_valid && dacc_write && dacc_partial && dtcm_en && dtcm_merge) |-> dacc_merge)
        else $error("narrow write not merged");
    a_size_field: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_sel && reg_addr == MACR_ADDR_ITCM)
            |-> reg_rdata[TM_SIZE_MSB:TM_SIZE_LSB] == ITCM_SIZE)
        else $error("size field wrong");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_sel && reg_addr == MACR_ADDR_PPORT) |-> reg_rdata[31:4] == 28'h000_0000)
        else $error("reserved bits not zero");
    a_strap_load: assert property (@(posedge mclk) disable iff (!rst_n)
        !rst_seen |=> itcm_en == $past(strap_s2[0]))
        else $error("strap not loaded");
    a_ecc_sense: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_sel && reg_addr == MACR_ADDR_CACHE) |-> cache_ecc_on == !reg_rdata[AC_ECC_BIT])
        else $error("ecc sense not inverted");
    a_ecc_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (rst_seen && wr_ok && reg_addr == MACR_ADDR_CACHE)
            |=> ecc_dis == (ecc_writable ? $past(reg_wdata[AC_ECC_BIT]) : $past(ecc_dis)))
        else $error("ecc bit write handling wrong");
    a_pport_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (rst_seen && wr_ok && reg_addr == MACR_ADDR_PPORT) |=> pport_en == $past(reg_wdata[0]))
        else $error("peripheral enable not written");
    a_shared_policy: assert property (@(posedge mclk) disable iff (!rst_n)
        (cacc_cacheable && cacc_shared && !shared_wt) |-> dcache_policy == MACR_POL_NC)
        else $error("shared location cached");

    c_itcm_enable: cover property (@(posedge mclk) disable iff (!rst_n)
        !itcm_en ##1 itcm_en);
    c_merge_write: cover property (@(posedge mclk) disable iff (!rst_n) dacc_merge);
    c_shared_wt: cover property (@(posedge mclk) disable iff (!rst_n)
        dcache_policy == MACR_POL_WT && cacc_shared);
    c_pport_axi: cover property (@(posedge mclk) disable iff (!rst_n) pacc_to_axi);
endmodule : macr_regs

// ---- macr_tm_route.sv ----
`timescale 1ns/1ps
// steering for one tightly coupled memory port
module macr_tm_route (
    // configuration
    macr_cfg_if.route       cfg,
    // access request
    input  wire logic       acc_valid,
    input  wire logic       acc_write,
    input  wire logic       acc_partial,
    input  wire logic       mem_retry,
    // steering
    output logic            to_mem,
    output logic            to_axi,
    output logic            use_merge,
    output logic            honour_retry
);
    always_comb begin
        to_mem       = acc_valid & cfg.enable;
        to_axi       = acc_valid & ~cfg.enable;
        use_merge    = to_mem & acc_write & acc_partial
                     & cfg.partial_write_merge_enable;
        honour_retry = to_mem & mem_retry & cfg.retry_enable;
    end
endmodule : macr_tm_route

// ---- memory_access_control_regs_tb.sv ----
`timescale 1ns/1ps
module memory_access_control_regs_tb;
    import macr_pkg::*;
    localparam logic [3:0] T_ISZ = 4'h3;
    localparam logic [3:0] T_DSZ = 4'hf;
    localparam logic [2:0] T_PSZ = 3'h4;
    logic         mclk, rst_n, reg_sel, reg_write, reg_priv, reg_hit;
    logic  [31:0] reg_addr, reg_wdata, reg_rdata, lfsr_state, r;
    logic  [4:0]  strap;
    logic         iacc_valid, iacc_write, iacc_partial, imem_retry;
    logic         iacc_to_mem, iacc_to_axi, iacc_merge, iacc_retry;
    logic         dacc_valid, dacc_write, dacc_partial, dmem_retry;
    logic         dacc_to_mem, dacc_to_axi, dacc_merge, dacc_retry;
    logic         pacc_valid, pacc_to_port, pacc_to_axi;
    logic         cacc_cacheable, cacc_shared, cacc_wback, cache_ecc_on;
    macr_policy_t dcache_policy, icache_policy;
    logic  [2:0]  ctl [4];
    logic  [31:0] addr_tab [5];
    int           err_total, check_count, cycles;

    macr_regs #(.ITCM_SIZE(T_ISZ), .DTCM_SIZE(T_DSZ), .PPORT_SIZE(T_PSZ)) macr_regs_i (
        .mclk(mclk), .rst_n(rst_n), .reg_sel(reg_sel), .reg_write(reg_write),
        .reg_priv(reg_priv), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .strap_itcm_en(strap[0]), .strap_dtcm_en(strap[1]), .strap_tm_retry(strap[2]),
        .strap_tm_merge(strap[3]), .strap_pport_en(strap[4]),
        .iacc_valid(iacc_valid), .iacc_write(iacc_write), .iacc_partial(iacc_partial),
        .imem_retry(imem_retry), .iacc_to_mem(iacc_to_mem), .iacc_to_axi(iacc_to_axi),
        .iacc_merge(iacc_merge), .iacc_retry(iacc_retry),
        .dacc_valid(dacc_valid), .dacc_write(dacc_write), .dacc_partial(dacc_partial),
        .dmem_retry(dmem_retry), .dacc_to_mem(dacc_to_mem), .dacc_to_axi(dacc_to_axi),
        .dacc_merge(dacc_merge), .dacc_retry(dacc_retry),
        .pacc_valid(pacc_valid), .pacc_to_port(pacc_to_port), .pacc_to_axi(pacc_to_axi),
        .cacc_cacheable(cacc_cacheable), .cacc_shared(cacc_shared),
        .cacc_wback(cacc_wback), .dcache_policy(dcache_policy),
        .icache_policy(icache_policy), .cache_ecc_on(cache_ecc_on)
    );

    macr_far_model macr_far_model_i (
        .mclk(mclk), .imem_retry(imem_retry), .dmem_retry(dmem_retry)
    );

    function automatic logic [31:0] rnd();
        lfsr_state = lfsr_state[0] ? (lfsr_state >> 1) ^ 32'h8020_0003 : lfsr_state >> 1;
        return lfsr_state;
    endfunction : rnd

    function automatic logic [31:0] exp_read(input int k);
        case (k)
            0: return {25'h000_0000, T_ISZ, ctl[0]};
            1: return {25'h000_0000, T_DSZ, ctl[1]};
            2: return {28'h000_0000, T_PSZ, ctl[2][0]};
            3: return {29'h0000_0000, ctl[3]};
            default: return 32'h0000_0000;
        endcase
    endfunction : exp_read

    function automatic macr_policy_t exp_dpol(input logic ca, input logic sh, input logic wb);
        if (!ca) return MACR_POL_NC;
        if (sh) return ctl[3][0] ? MACR_POL_WT : MACR_POL_NC;
        return (!wb || ctl[3][2]) ? MACR_POL_WT : MACR_POL_WB;
    endfunction : exp_dpol

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    // request stays up until the next call moves it at the following falling edge
    task automatic wr(input int k, input logic [31:0] d, input logic p);
        @(negedge mclk);
        reg_sel   = 1'b1;
        reg_write = 1'b1;
        reg_priv  = p;
        reg_addr  = addr_tab[k];
        reg_wdata = d;
        if (p && k < 4) begin
            ctl[k] = (k == 2) ? {2'b00, d[0]} : d[2:0];
        end
    endtask : wr

    task automatic rd(input int k);
        logic [31:0] q;
        @(negedge mclk);
        q         = rnd();
        reg_sel   = 1'b1;
        reg_write = 1'b0;
        reg_priv  = q[0];
        reg_addr  = addr_tab[k];
        #2;
        chk("reg_rdata", reg_rdata, exp_read(k));
        chk("reg_hit", reg_hit, k < 4);
    endtask : rd

    // idle ports must stay off both paths, so every output is compared each time
    task automatic chk_tm(input logic [2:0] c, input logic v, w, pt, rt, tm, ta, mg, hr);
        chk("to_mem", tm, v & c[0]);
        chk("to_axi", ta, v & !c[0]);
        chk("merge", mg, v & c[0] & w & pt & c[1]);
        chk("retry", hr, v & c[0] & rt & c[2]);
    endtask : chk_tm

    // straps change only while reset is held, so the synchroniser settles first
    task automatic reset_dut();
        logic [31:0] q;
        rst_n = 1'b0;
        q     = rnd();
        strap = q[4:0];
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        rst_n  = 1'b1;
        ctl[0] = {strap[2], strap[3], strap[0]};
        ctl[1] = {strap[2], strap[3], strap[1]};
        ctl[2] = {2'b00, strap[4]};
        ctl[3] = 3'b000;
        @(negedge mclk);
        for (int k = 0; k < 5; k++) rd(k);
        repeat (8) route();
    endtask : reset_dut

    task automatic route();
        @(negedge mclk);
        reg_sel = 1'b0;
        r = rnd();
        {iacc_valid, iacc_write, iacc_partial, dacc_valid, dacc_write} = r[4:0];
        {dacc_partial, pacc_valid, cacc_cacheable, cacc_shared, cacc_wback} = r[9:5];
        #2;
        chk_tm(ctl[0], iacc_valid, iacc_write, iacc_partial, imem_retry,
               iacc_to_mem, iacc_to_axi, iacc_merge, iacc_retry);
        chk_tm(ctl[1], dacc_valid, dacc_write, dacc_partial, dmem_retry,
               dacc_to_mem, dacc_to_axi, dacc_merge, dacc_retry);
        chk("to_port", pacc_to_port, pacc_valid & ctl[2][0]);
        chk("p_axi", pacc_to_axi, pacc_valid & !ctl[2][0]);
        chk("dpol", dcache_policy,
            exp_dpol(cacc_cacheable, cacc_shared, cacc_wback));
        chk("ipol", icache_policy,
            (cacc_cacheable && !cacc_shared) ? MACR_POL_WB : MACR_POL_NC);
        chk("ecc_on", cache_ecc_on, !ctl[3][1]);
    endtask : route

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        addr_tab = '{MACR_ADDR_ITCM, MACR_ADDR_DTCM, MACR_ADDR_PPORT, MACR_ADDR_CACHE,
                     32'he000_efa0};
        lfsr_state = 32'h0000_0061;
        {err_total, check_count, cycles} = '0;
        {reg_sel, reg_write, reg_priv, reg_addr, reg_wdata} = '0;
        {iacc_valid, iacc_write, iacc_partial, dacc_valid, dacc_write} = '0;
        {dacc_partial, pacc_valid, cacc_cacheable, cacc_shared, cacc_wback} = '0;
        reset_dut();
        $display("test reset values done");
        wr(0, 32'h0000_0006, 1'b1);
        wr(1, 32'h0000_0006, 1'b1);
        // caches and ECC are left at their defaults here, so the ecc bit takes the write
        for (int k = 0; k < 5; k++) wr(k, 32'hffff_ffff, 1'b1);
        for (int k = 0; k < 5; k++) rd(k);
        repeat (8) route();
        for (int k = 0; k < 5; k++) wr(k, 32'h0000_0000, 1'b0);
        for (int k = 0; k < 5; k++) rd(k);
        repeat (8) route();
        $display("test corner writes done");
        // second reset in mid-run: fresh straps reload, written bits are lost
        reset_dut();
        $display("test second reset done");
        repeat (300) begin
            wr(rnd() % 5, rnd(), (rnd() & 32'h0000_0003) != 0);
            rd(rnd() % 5);
            repeat (2) route();
        end
        $display("test random traffic done");
        close_out();
    end
endmodule : memory_access_control_regs_tb
